// ==== rtl/crs_top.sv ====
// crs_top: role selection and host write-strobe handling for the card interface
// assumes host pins are asynchronous and data is stable around the strobe's rising edge
`timescale 1ns/1ns
module crs_top
  import crs_pkg::*;
#(
  parameter int unsigned DATA_W = CRS_DATA_W
)
(
  input wire logic sys_clk_in,
  input wire logic srst_in,
  input wire crs_mode_t mode_in,
  input wire logic udma_active_in,
  input wire logic wr_strobe_n_in,
  input wire logic role_sel_n_in,
  input wire logic [DATA_W-1:0] host_data_in,
  output logic is_master_out,
  output logic role_valid_out,
  output logic [DATA_W-1:0] wr_data_out,
  output logic wr_valid_out,
  output logic burst_stop_out
);
  crs_pin_if pins (); // synchronised pin levels

  crs_pin_sync u_sync
  (
    .sys_clk_in(sys_clk_in),
    .srst_in(srst_in),
    .wr_strobe_n_pin_in(wr_strobe_n_in),
    .role_sel_n_pin_in(role_sel_n_in),
    .pins(pins)
  );

  // data pins pass two stages too, aligned with the strobe synchroniser
  logic [DATA_W-1:0] data_s1_ff;
  logic [DATA_W-1:0] data_s2_ff;
  logic [DATA_W-1:0] nxt_data_s1;
  logic [DATA_W-1:0] nxt_data_s2;
  logic strobe_prev_ff; // last synchronised strobe level
  logic nxt_strobe_prev;

  // role latch state
  crs_rl_state_t rl_state_ff;
  crs_rl_state_t nxt_rl_state;
  logic [1:0] rl_cnt_ff; // settle delay after reset release
  logic [1:0] nxt_rl_cnt;
  logic is_master_ff;
  logic nxt_is_master;
  logic role_valid_ff;
  logic nxt_role_valid;

  // strobe outputs
  logic [DATA_W-1:0] wr_data_ff;
  logic [DATA_W-1:0] nxt_wr_data;
  logic wr_valid_ff;
  logic nxt_wr_valid;
  logic burst_stop_ff;
  logic nxt_burst_stop;
  logic stop_held_ff; // strobe went low as a stop request and has not risen yet
  logic nxt_stop_held;

  logic strobe_rise; // trailing edge of the active-low strobe
  logic strobe_fall; // leading edge, asserting the strobe
  logic burst_on; // IDE mode with a burst running

  // edge detect reads only the second synchroniser stage
  always_comb
  begin
    strobe_rise = (strobe_prev_ff == 1'b0) && (pins.wr_strobe_n == CRS_STROBE_IDLE);
    strobe_fall = (strobe_prev_ff == CRS_STROBE_IDLE) && (pins.wr_strobe_n == 1'b0);
    burst_on = (mode_in == CRS_MODE_IDE) && udma_active_in;
  end

  // data and strobe history pipeline
  always_comb
  begin
    if (srst_in)
    begin
      nxt_data_s1 = '0;
      nxt_data_s2 = '0;
      nxt_strobe_prev = CRS_STROBE_IDLE;
    end
    else
    begin
      nxt_data_s1 = host_data_in;
      nxt_data_s2 = data_s1_ff;
      nxt_strobe_prev = pins.wr_strobe_n;
    end
  end

  always_ff @(posedge sys_clk_in)
  begin
    data_s1_ff <= nxt_data_s1;
    data_s2_ff <= nxt_data_s2;
    strobe_prev_ff <= nxt_strobe_prev;
  end

  // role latch: waits for the synchroniser to fill, samples once, then holds
  // the role is a strap, so it is not re-read later even if the pin moves
  always_comb
  begin
    nxt_rl_state = rl_state_ff;
    nxt_rl_cnt = rl_cnt_ff;
    nxt_is_master = is_master_ff;
    nxt_role_valid = role_valid_ff;
    if (srst_in)
    begin
      nxt_rl_state = CRS_RL_WAIT;
      nxt_rl_cnt = '0;
      nxt_is_master = CRS_ROLE_SLAVE;
      nxt_role_valid = 1'b0;
    end
    else
    begin
      unique case (rl_state_ff)
        CRS_RL_WAIT:
        begin
          nxt_rl_cnt = rl_cnt_ff + 2'h1;
          if (rl_cnt_ff == CRS_LATCH_DELAY)
          begin
            nxt_rl_state = CRS_RL_SAMPLE;
          end
        end
        CRS_RL_SAMPLE:
        begin
          nxt_rl_state = CRS_RL_HELD;
          nxt_role_valid = 1'b1;
          if (mode_in == CRS_MODE_IDE)
          begin
            // pull-up makes an open pin read high
            if (pins.role_sel_n == 1'b0)
            begin
              nxt_is_master = CRS_ROLE_MASTER;
            end
            else
            begin
              nxt_is_master = CRS_ROLE_SLAVE;
            end
          end
          else
          begin
            nxt_is_master = CRS_ROLE_SLAVE;
          end
        end
        CRS_RL_HELD:
        begin
          nxt_rl_state = CRS_RL_HELD;
        end
        default:
        begin
          nxt_rl_state = CRS_RL_WAIT;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk_in)
  begin
    rl_state_ff <= nxt_rl_state;
    rl_cnt_ff <= nxt_rl_cnt;
    is_master_ff <= nxt_is_master;
    role_valid_ff <= nxt_role_valid;
  end

  // write strobe: capture on trailing edge, or stop request while a burst runs
  // a stop that outlives its burst must not turn into a write when released
  always_comb
  begin
    nxt_wr_data = wr_data_ff;
    nxt_wr_valid = 1'b0;
    nxt_burst_stop = 1'b0;
    nxt_stop_held = stop_held_ff;
    if (srst_in)
    begin
      nxt_wr_data = '0;
      nxt_stop_held = 1'b0;
    end
    else if (burst_on)
    begin
      // strobe carries no data here; its assertion ends the burst
      nxt_burst_stop = strobe_fall;
      if (strobe_fall)
      begin
        nxt_stop_held = 1'b1;
      end
      else if (strobe_rise)
      begin
        nxt_stop_held = 1'b0;
      end
    end
    else if ((mode_in == CRS_MODE_IO) || (mode_in == CRS_MODE_IDE))
    begin
      if (strobe_rise)
      begin
        nxt_stop_held = 1'b0;
        // trailing edge of a stop request whose burst already ended has no data
        if (!stop_held_ff)
        begin
          nxt_wr_data = data_s2_ff;
          nxt_wr_valid = 1'b1;
        end
      end
    end
    else if (strobe_rise)
    begin
      // memory mode: no write, but a stale stop is dropped so it cannot eat a later one
      nxt_stop_held = 1'b0;
    end
  end

  always_ff @(posedge sys_clk_in)
  begin
    wr_data_ff <= nxt_wr_data;
    wr_valid_ff <= nxt_wr_valid;
    burst_stop_ff <= nxt_burst_stop;
    stop_held_ff <= nxt_stop_held;
  end

  assign is_master_out = is_master_ff;
  assign role_valid_out = role_valid_ff;
  assign wr_data_out = wr_data_ff;
  assign wr_valid_out = wr_valid_ff;
  assign burst_stop_out = burst_stop_ff;
endmodule

// ==== rtl/crs_pkg.sv ====
// crs_pkg: shared constants and types for the role-select and write-strobe block
// assumes a single 10 MHz system clock and synchronous active-high reset
package crs_pkg;
  localparam int unsigned CRS_DATA_W = 16; // host data bus width
  localparam int unsigned CRS_SYNC_STAGES = 2; // synchroniser depth on pins
  localparam logic CRS_ROLE_MASTER = 1'b1; // role code for master drive
  localparam logic CRS_ROLE_SLAVE = 1'b0; // role code for slave drive
  localparam logic CRS_STROBE_IDLE = 1'b1; // negated level of the active-low strobe
  localparam logic [1:0] CRS_LATCH_DELAY = 2'h2; // wait count that ends the delay after release; role is caught the cycle after

  // operating mode as seen by this block
  typedef enum logic [1:0]
  {
    CRS_MODE_MEM,
    CRS_MODE_IO,
    CRS_MODE_IDE
  } crs_mode_t;

  // role latch sequencer
  typedef enum logic [1:0]
  {
    CRS_RL_WAIT,
    CRS_RL_SAMPLE,
    CRS_RL_HELD
  } crs_rl_state_t;
endpackage

// ==== rtl/crs_pin_if.sv ====
// crs_pin_if: synchronised pin levels passed from the synchroniser to the core
// assumes both ends run on the one system clock
`timescale 1ns/1ns
interface crs_pin_if;
  logic wr_strobe_n; // synchronised active-low write strobe
  logic role_sel_n; // synchronised role-select pin, low means grounded
  modport src (output wr_strobe_n, output role_sel_n);
  modport dst (input wr_strobe_n, input role_sel_n);
endinterface

// ==== rtl/crs_pin_sync.sv ====
// crs_pin_sync: two-flop synchronisers for the asynchronous strobe and role-select host pins
// assumes pins change freely relative to sys_clk_in
`timescale 1ns/1ns
module crs_pin_sync
  import crs_pkg::*;
(
  input wire logic sys_clk_in,
  input wire logic srst_in,
  input wire logic wr_strobe_n_pin_in,
  input wire logic role_sel_n_pin_in,
  crs_pin_if.src pins
);
  logic [1:0] wr_sync_ff; // stage 0 is read only by stage 1
  logic [1:0] role_sync_ff;
  logic [1:0] nxt_wr_sync;
  logic [1:0] nxt_role_sync;

  // shift pins through two stages; reset to idle-high so no false edge
  always_comb
  begin
    if (srst_in)
    begin
      nxt_wr_sync = {2{CRS_STROBE_IDLE}};
      nxt_role_sync = 2'h3;
    end
    else
    begin
      nxt_wr_sync = {wr_sync_ff[0], wr_strobe_n_pin_in};
      nxt_role_sync = {role_sync_ff[0], role_sel_n_pin_in};
    end
  end

  // registers only
  always_ff @(posedge sys_clk_in)
  begin
    wr_sync_ff <= nxt_wr_sync;
    role_sync_ff <= nxt_role_sync;
  end

  assign pins.wr_strobe_n = wr_sync_ff[1];
  assign pins.role_sel_n = role_sync_ff[1];
endmodule

// ==== sim/crs_host_model.sv ====
// crs_host_model: host side driving the write strobe and data pins
// assumes the bench calls its tasks and supplies the system clock
`timescale 1ns/1ns
module crs_host_model
  import crs_pkg::*;
(
  input wire logic clk_in,
  output logic wr_strobe_n_out,
  output logic [CRS_DATA_W-1:0] data_out
);
  // strobe starts negated so no burst ever begins with it asserted
  initial
  begin
    wr_strobe_n_out = CRS_STROBE_IDLE;
    data_out = 16'h0000;
  end
  // one strobe pulse; the bus settles one cycle after the strobe falls, so a
  // leading-edge capture would take the wrong word; data held past release
  task automatic pulse(input logic [CRS_DATA_W-1:0] d);
    @(posedge clk_in);
    #1 wr_strobe_n_out = 1'b0;
    data_out = ~d;
    @(posedge clk_in);
    #1 data_out = d;
    repeat (3) @(posedge clk_in);
    #1 wr_strobe_n_out = CRS_STROBE_IDLE;
    repeat (7) @(posedge clk_in);
    #1 data_out = ~d; // released bus shows no stale value
  endtask
endmodule

// ==== sim/crs_top_monitor.sv ====
// crs_top_monitor: timing checks on the crs_top ports
// assumes one clock domain and synchronous reset
`timescale 1ns/1ns
module crs_top_monitor
  import crs_pkg::*;
(
  input wire logic sys_clk_in,
  input wire logic srst_in,
  input wire crs_mode_t mode_in,
  input wire logic udma_active_in,
  input wire logic wr_strobe_n_in,
  input wire logic role_sel_n_in,
  input wire logic is_master_out,
  input wire logic role_valid_out,
  input wire logic wr_valid_out,
  input wire logic burst_stop_out
);
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (srst_in);
  logic stop_low_ff; // strobe asserted as a stop request and not yet released
  // helper: tracks a stop request so its release is not expected to write
  always @(posedge sys_clk_in)
  begin
    if (srst_in)
      stop_low_ff <= 1'b0;
    else if (mode_in == CRS_MODE_IDE && udma_active_in && $fell(wr_strobe_n_in))
      stop_low_ff <= 1'b1;
    else if ($rose(wr_strobe_n_in))
      stop_low_ff <= 1'b0;
  end
  property p_io_cap; mode_in == CRS_MODE_IO && $rose(wr_strobe_n_in) |-> ##[1:5] wr_valid_out; endproperty
  a_io_cap: assert property (p_io_cap) else $error("no write pulse in io mode");
  property p_ide_cap; mode_in == CRS_MODE_IDE && !udma_active_in && !stop_low_ff && $rose(wr_strobe_n_in) |->
    ##[1:5] wr_valid_out; endproperty
  a_ide_cap: assert property (p_ide_cap) else $error("no write pulse in ide mode");
  property p_trail; wr_valid_out |-> $past(wr_strobe_n_in, 2); endproperty
  a_trail: assert property (p_trail) else $error("write taken on leading edge");
  property p_stop; mode_in == CRS_MODE_IDE && udma_active_in && $fell(wr_strobe_n_in) |-> ##[1:5] burst_stop_out;
  endproperty
  a_stop: assert property (p_stop) else $error("no burst stop pulse");
  property p_stop_no_wr; mode_in == CRS_MODE_IDE && !udma_active_in && stop_low_ff && $rose(wr_strobe_n_in) |=>
    !wr_valid_out [*5]; endproperty
  a_stop_no_wr: assert property (p_stop_no_wr) else $error("stop release taken as write");
  property p_role_ide; $rose(role_valid_out) && mode_in == CRS_MODE_IDE |-> is_master_out == !role_sel_n_in; endproperty
  a_role_ide: assert property (p_role_ide) else $error("wrong role in ide mode");
  property p_role_card; $rose(role_valid_out) && mode_in != CRS_MODE_IDE |-> is_master_out == CRS_ROLE_SLAVE; endproperty
  a_role_card: assert property (p_role_card) else $error("role pin used in card mode");
  property p_role_time; $fell(srst_in) |-> ##[3:6] role_valid_out; endproperty
  a_role_time: assert property (p_role_time) else $error("role not latched");
  property p_role_fix; role_valid_out && $past(role_valid_out) |-> $stable(is_master_out); endproperty
  a_role_fix: assert property (p_role_fix) else $error("role changed after latch");
endmodule
bind crs_top crs_top_monitor u_mon (.sys_clk_in(sys_clk_in), .srst_in(srst_in), .mode_in(mode_in),
  .udma_active_in(udma_active_in), .wr_strobe_n_in(wr_strobe_n_in), .role_sel_n_in(role_sel_n_in),
  .is_master_out(is_master_out), .role_valid_out(role_valid_out), .wr_valid_out(wr_valid_out),
  .burst_stop_out(burst_stop_out));

// ==== sim/tb_crs_top.sv ====
// tb_crs_top: self-checking bench for crs_top with a host model on the pins
// assumes a 10 MHz clock; inputs change 1 or 2 ns after the rising edge
`timescale 1ns/1ns
module tb_crs_top;
  import crs_pkg::*;
  logic sys_clk_in = 1'b0, srst_in = 1'b1, udma = 1'b0, role_gnd = 1'b0, is_m, r_v, w_v, b_s;
  logic wr_n;
  logic [CRS_DATA_W-1:0] hd, wd;
  crs_mode_t mode = CRS_MODE_IDE;
  int errors = 0, cmp_count = 0, n_wr = 0, n_stop = 0, cycles = 0;
  initial forever #50 sys_clk_in = ~sys_clk_in;
  crs_host_model host (.clk_in(sys_clk_in), .wr_strobe_n_out(wr_n), .data_out(hd));
  crs_top uut (.sys_clk_in(sys_clk_in), .srst_in(srst_in), .mode_in(mode), .udma_active_in(udma),
    .wr_strobe_n_in(wr_n), .role_sel_n_in(!role_gnd), .host_data_in(hd), .is_master_out(is_m),
    .role_valid_out(r_v), .wr_data_out(wd), .wr_valid_out(w_v), .burst_stop_out(b_s));
  // pulse counters and hang guard
  always @(posedge sys_clk_in)
  begin
    n_wr <= n_wr + (w_v === 1'b1);
    n_stop <= n_stop + (b_s === 1'b1);
    cycles <= cycles + 1;
    if (cycles == 5000)
    begin
      errors++;
      tally_and_finish();
    end
  end
  task automatic chk(input string what, input logic [CRS_DATA_W-1:0] exp, input logic [CRS_DATA_W-1:0] got);
    cmp_count++;
    if (got !== exp)
    begin
      errors++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  // reset with a given mode and role pin; open pin reads high by pull-up
  task automatic do_reset(input crs_mode_t m, input logic gnd);
    @(posedge sys_clk_in);
    #1 srst_in = 1'b1;
    mode = m;
    role_gnd = gnd;
    repeat (16) @(posedge sys_clk_in);
    #1 srst_in = 1'b0;
    repeat (8) @(posedge sys_clk_in);
  endtask
  task automatic t_role(input crs_mode_t m, input logic gnd, input logic exp);
    do_reset(m, gnd);
    chk("role_valid", 16'h0001, {15'h0, r_v});
    chk("is_master", {15'h0, exp}, {15'h0, is_m});
    #1 role_gnd = ~gnd;
    repeat (6) @(posedge sys_clk_in);
    chk("is_master held", {15'h0, exp}, {15'h0, is_m});
    $display("test role done");
  endtask
  // one host write; expected count of write and stop pulses, and data if written
  task automatic t_write(input crs_mode_t m, input logic u, input logic [CRS_DATA_W-1:0] d, input int ew, es);
    int w0, s0;
    #1 mode = m;
    udma = u;
    w0 = n_wr;
    s0 = n_stop;
    host.pulse(d);
    chk("write pulses", ew[15:0], 16'(n_wr - w0));
    chk("stop pulses", es[15:0], 16'(n_stop - s0));
    if (ew == 1)
      chk("write data", d, wd);
    $display("test write done");
  endtask
  // stop request whose burst ends before the host releases the strobe
  task automatic t_stop_release(input logic [CRS_DATA_W-1:0] d);
    int w0, s0;
    #1 mode = CRS_MODE_IDE;
    udma = 1'b1;
    w0 = n_wr;
    s0 = n_stop;
    fork
      host.pulse(d);
      begin
        repeat (4) @(posedge sys_clk_in);
        #1 udma = 1'b0;
      end
    join
    chk("stop pulses", 16'h0001, 16'(n_stop - s0));
    chk("write pulses", 16'h0000, 16'(n_wr - w0));
    $display("test stop release done");
  endtask
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial
  begin
    t_role(CRS_MODE_IDE, 1'b1, CRS_ROLE_MASTER);
    t_role(CRS_MODE_IDE, 1'b0, CRS_ROLE_SLAVE);
    t_role(CRS_MODE_IO, 1'b1, CRS_ROLE_SLAVE);
    t_write(CRS_MODE_IO, 1'b0, 16'ha5c3, 1, 0);
    t_write(CRS_MODE_IO, 1'b0, 16'h5a3c, 1, 0);
    t_write(CRS_MODE_MEM, 1'b0, 16'hffff, 0, 0);
    t_write(CRS_MODE_IDE, 1'b0, 16'h0001, 1, 0);
    t_write(CRS_MODE_IDE, 1'b1, 16'h8000, 0, 1);
    t_stop_release(16'h1234);
    tally_and_finish();
  end
endmodule
